// ===== acsc_pkg.sv
// Overview of operation
// - Start bit launches conversion, clears when done.
// - Start writes during conversion do not restart it; only their output-enable bit takes effect.
// - Reference select: zero bandgap, one supply.
// - Two-bit input select steers 4:1 mux.
// - Averaging code selects 1 to 32 conversions.
// - One conversion takes 12 conversion-clock edges.
// - Total time is 12 x average x divisor.
// - Output idles released, driven high while busy.
// - On completion result stored, output driven low.
// - Output enabled: result shifts MSB first.
// - Chip select rising after a result shift releases the output line unless the word just shifted in starts a conversion; busy and ready levels stay driven.
// - Output disabled: result never presented.
// - Each 16-bit input word to a mapped address updates a register.
// - Address 1111 writes change no register.
// - Three 12-bit DACs with defined power-up levels.
// - Shutdown zeroes DACs; wakeup restores values.
// - Standby and idle keep DAC values.
// - Sixteen bits MSB first, latched on select rising.
package acsc_pkg;

  localparam int WORD_BITS   = 16;
  localparam int ADDR_BITS   = 4;
  localparam int RESULT_BITS = 10;
  localparam int DAC_BITS    = 12;
  localparam int ACC_BITS    = 15;

  localparam logic [4:0] BIT_CNT_FULL  = 5'h10;
  localparam logic [3:0] SAMPLE_EDGE   = 4'h0;
  localparam logic [3:0] LOAD_EDGE     = 4'hB;
  localparam logic [3:0] MSB_INDEX     = 4'hA;
  localparam logic [2:0] AVG_SHIFT_MAX = 3'h5;
  localparam logic [9:0] TRIAL_MSB     = 10'h200;

  localparam logic [3:0] ADDR_ADC_CTRL = 4'h1;
  localparam logic [3:0] ADDR_DAC_FREQ = 4'h2;
  localparam logic [3:0] ADDR_DAC_GAIN = 4'h3;
  localparam logic [3:0] ADDR_DAC_AGC  = 4'h4;
  localparam logic [3:0] ADDR_POWER    = 4'h5;

  typedef struct packed {
    logic       result_output_enable;
    logic [2:0] clock_divisor;
    logic [2:0] averaging_count;
    logic [1:0] input_select;
    logic       reference_select_field;
    logic       start_convert_field;
  } acsc_cfg_t;

  localparam acsc_cfg_t CFG_RESET = acsc_cfg_t'(11'h000);

  typedef struct packed {
    logic [11:0] frequency_control_output;
    logic [11:0] gain_control_output;
    logic [11:0] auto_gain_output;
  } acsc_dac_t;

  typedef enum logic [1:0] {
    PWR_NORMAL     = 2'b00,
    PWR_IDLE       = 2'b01,
    standby_state  = 2'b10,
    shutdown_state = 2'b11
  } acsc_pwr_t;

  typedef enum logic [1:0] {
    DOUT_RELEASED = 2'b00,
    DOUT_BUSY     = 2'b01,
    DOUT_READY    = 2'b10,
    DOUT_SHIFT    = 2'b11
  } acsc_dout_t;

endpackage

// ===== acsc_aux_converter.sv
module acsc_aux_converter #(
  parameter logic [11:0] FREQ_DAC_PRESET = 12'h700
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_cs_n,
  input  wire logic              i_sclk,
  input  wire logic              i_din,
  input  wire logic              i_sar_cmp,
  output logic                   o_dout,
  output logic                   o_dout_oe,
  output logic                   o_sample,
  output logic [9:0]             o_sar_trial,
  output logic [1:0]             o_input_select,
  output logic                   o_reference_select,
  output logic                   o_adc_busy,
  output acsc_pkg::acsc_dac_t    o_dac,
  output logic                   o_dac_off
);

  function automatic logic [2:0] avg_shift(input logic [2:0] code);
    return (code > acsc_pkg::AVG_SHIFT_MAX) ? acsc_pkg::AVG_SHIFT_MAX : code;
  endfunction

  function automatic logic [6:0] div_last(input logic [2:0] code);
    return 7'((8'h01 << code) - 8'h01);
  endfunction

  // Pin synchronisers; stage two feeds logic, stage three only marks edges.
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1 <= 3'h7;
      sync2 <= 3'h7;
      sync3 <= 3'h7;
    end else begin
      sync1 <= {i_cs_n, i_sclk, i_din};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  logic cs_n_s;
  logic din_s;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;

  assign cs_n_s    = sync2[2];
  assign din_s     = sync2[0];
  assign cs_fall   = sync3[2] & ~sync2[2];
  assign cs_rise   = ~sync3[2] & sync2[2];
  assign sclk_rise = ~sync3[1] & sync2[1];
  assign sclk_fall = sync3[1] & ~sync2[1];

  logic [15:0]           shift_in;
  logic [4:0]            bit_cnt;
  acsc_pkg::acsc_cfg_t   cfg;
  acsc_pkg::acsc_cfg_t   run;
  logic                  busy;
  logic [6:0]            div_cnt;
  logic [3:0]            edge_cnt;
  logic [4:0]            avg_cnt;
  logic [14:0]           acc;
  logic [9:0]            trial;
  logic [9:0]            result;
  logic [9:0]            out_shift;
  acsc_pkg::acsc_dout_t  dstate;
  acsc_pkg::acsc_dac_t   dac;
  acsc_pkg::acsc_pwr_t   pwr;

  logic [15:0]           next_shift_in;
  logic [4:0]            next_bit_cnt;
  acsc_pkg::acsc_cfg_t   next_cfg;
  acsc_pkg::acsc_cfg_t   next_run;
  logic                  next_busy;
  logic [6:0]            next_div_cnt;
  logic [3:0]            next_edge_cnt;
  logic [4:0]            next_avg_cnt;
  logic [14:0]           next_acc;
  logic [9:0]            next_trial;
  logic [9:0]            next_result;
  logic [9:0]            next_out_shift;
  acsc_pkg::acsc_dout_t  next_dstate;
  acsc_pkg::acsc_dac_t   next_dac;
  acsc_pkg::acsc_pwr_t   next_pwr;
  logic                  next_dout;
  logic                  next_sample;
  acsc_pkg::acsc_dac_t   next_o_dac;

  logic                  latch;
  logic [3:0]            wr_addr;
  logic [11:0]           wr_data;
  acsc_pkg::acsc_cfg_t   wr_cfg;
  logic                  tick;
  logic                  last_conv;
  logic                  done;
  logic [3:0]            bit_idx;
  logic [14:0]           sum;

  assign latch     = cs_rise && (bit_cnt == acsc_pkg::BIT_CNT_FULL);
  assign wr_addr   = shift_in[15:12];
  assign wr_data   = shift_in[11:0];
  assign wr_cfg    = acsc_pkg::acsc_cfg_t'(wr_data[10:0]);
  assign tick      = busy && (div_cnt == div_last(run.clock_divisor));
  assign last_conv = avg_cnt == 5'((6'h01 << avg_shift(run.averaging_count)) - 6'h01);
  assign done      = tick && (edge_cnt == acsc_pkg::LOAD_EDGE) && last_conv;
  assign bit_idx   = acsc_pkg::MSB_INDEX - edge_cnt;
  assign sum       = acc + 15'(trial);

  always_comb begin
    next_shift_in  = shift_in;
    next_bit_cnt   = bit_cnt;
    next_cfg       = cfg;
    next_run       = run;
    next_busy      = busy;
    next_div_cnt   = div_cnt;
    next_edge_cnt  = edge_cnt;
    next_avg_cnt   = avg_cnt;
    next_acc       = acc;
    next_trial     = trial;
    next_result    = result;
    next_out_shift = out_shift;
    next_dstate    = dstate;
    next_dac       = dac;
    next_pwr       = pwr;

    // Serial input runs whatever the output line is doing.
    if (cs_fall) begin
      next_bit_cnt = 5'h00;
    end else if (!cs_n_s && sclk_rise) begin
      next_shift_in = {shift_in[14:0], din_s};
      if (bit_cnt != acsc_pkg::BIT_CNT_FULL) begin
        next_bit_cnt = bit_cnt + 5'h01;
      end
    end

    // Conversion engine, advanced once per conversion-clock enable.
    if (tick) begin
      next_div_cnt = 7'h00;
      if (edge_cnt == acsc_pkg::SAMPLE_EDGE) begin
        next_trial = acsc_pkg::TRIAL_MSB;
        next_edge_cnt = edge_cnt + 4'h1;
      end else if (edge_cnt == acsc_pkg::LOAD_EDGE) begin
        next_acc = sum;
        next_edge_cnt = acsc_pkg::SAMPLE_EDGE;
        next_avg_cnt = avg_cnt + 5'h01;
        if (done) begin
          next_result = 10'(sum >> avg_shift(run.averaging_count));
          next_busy = 1'b0;
          next_dstate = acsc_pkg::DOUT_READY;
        end
      end else begin
        next_trial[bit_idx] = i_sar_cmp;
        if (bit_idx != 4'h0) begin
          next_trial[bit_idx - 4'h1] = 1'b1;
        end
        next_edge_cnt = edge_cnt + 4'h1;
      end
    end else if (busy) begin
      next_div_cnt = div_cnt + 7'h01;
    end

    // Output line sequencing.
    unique case (dstate)
      acsc_pkg::DOUT_RELEASED: begin
      end
      acsc_pkg::DOUT_BUSY: begin
      end
      acsc_pkg::DOUT_READY: begin
        if (cs_fall) begin
          if (cfg.result_output_enable) begin
            next_dstate = acsc_pkg::DOUT_SHIFT;
            next_out_shift = result;
          end else begin
            next_dstate = acsc_pkg::DOUT_RELEASED;
          end
        end
      end
      acsc_pkg::DOUT_SHIFT: begin
        if (cs_rise) begin
          next_dstate = acsc_pkg::DOUT_RELEASED;
        end else if (!cs_n_s && sclk_fall) begin
          next_out_shift = {out_shift[8:0], 1'b0};
        end
      end
    endcase

    // Register writes; unlisted addresses, 1111 among them, fall through untouched.
    if (latch) begin
      unique case (wr_addr)
        acsc_pkg::ADDR_ADC_CTRL: begin
          next_cfg = wr_cfg;
          if (busy) begin
            next_cfg.start_convert_field = cfg.start_convert_field;
          end else if (wr_cfg.start_convert_field) begin
            next_run = wr_cfg;
            next_busy = 1'b1;
            next_div_cnt = 7'h00;
            next_edge_cnt = acsc_pkg::SAMPLE_EDGE;
            next_avg_cnt = 5'h00;
            next_acc = 15'h0000;
            next_dstate = acsc_pkg::DOUT_BUSY;
          end
        end
        acsc_pkg::ADDR_DAC_FREQ: next_dac.frequency_control_output = wr_data;
        acsc_pkg::ADDR_DAC_GAIN: next_dac.gain_control_output = wr_data;
        acsc_pkg::ADDR_DAC_AGC:  next_dac.auto_gain_output = wr_data;
        acsc_pkg::ADDR_POWER:    next_pwr = acsc_pkg::acsc_pwr_t'(wr_data[1:0]);
        default: begin
        end
      endcase
    end
    next_cfg.start_convert_field = next_busy;

    unique case (next_dstate)
      acsc_pkg::DOUT_BUSY:  next_dout = 1'b1;
      acsc_pkg::DOUT_SHIFT: next_dout = next_out_shift[9];
      default:              next_dout = 1'b0;
    endcase

    next_sample = tick && (edge_cnt == acsc_pkg::SAMPLE_EDGE);
    // Stored codes survive shutdown so wakeup restores them.
    next_o_dac = (next_pwr == acsc_pkg::shutdown_state) ? acsc_pkg::acsc_dac_t'(36'h0) : next_dac;
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      shift_in           <= 16'h0000;
      bit_cnt            <= 5'h00;
      cfg                <= acsc_pkg::CFG_RESET;
      run                <= acsc_pkg::CFG_RESET;
      busy               <= 1'b0;
      div_cnt            <= 7'h00;
      edge_cnt           <= 4'h0;
      avg_cnt            <= 5'h00;
      acc                <= 15'h0000;
      trial              <= 10'h000;
      result             <= 10'h000;
      out_shift          <= 10'h000;
      dstate             <= acsc_pkg::DOUT_RELEASED;
      dac                <= {FREQ_DAC_PRESET, 12'h000, 12'h000};
      pwr                <= acsc_pkg::PWR_NORMAL;
      o_dout             <= 1'b0;
      o_dout_oe          <= 1'b0;
      o_sample           <= 1'b0;
      o_sar_trial        <= 10'h000;
      o_input_select     <= 2'h0;
      o_reference_select <= 1'b0;
      o_adc_busy         <= 1'b0;
      o_dac              <= {FREQ_DAC_PRESET, 12'h000, 12'h000};
      o_dac_off          <= 1'b0;
    end else begin
      shift_in           <= next_shift_in;
      bit_cnt            <= next_bit_cnt;
      cfg                <= next_cfg;
      run                <= next_run;
      busy               <= next_busy;
      div_cnt            <= next_div_cnt;
      edge_cnt           <= next_edge_cnt;
      avg_cnt            <= next_avg_cnt;
      acc                <= next_acc;
      trial              <= next_trial;
      result             <= next_result;
      out_shift          <= next_out_shift;
      dstate             <= next_dstate;
      dac                <= next_dac;
      pwr                <= next_pwr;
      o_dout             <= next_dout;
      o_dout_oe          <= next_dstate != acsc_pkg::DOUT_RELEASED;
      o_sample           <= next_sample;
      o_sar_trial        <= next_trial;
      o_input_select     <= next_run.input_select;
      o_reference_select <= next_run.reference_select_field;
      o_adc_busy         <= next_busy;
      o_dac              <= next_o_dac;
      o_dac_off          <= next_pwr == acsc_pkg::shutdown_state;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  AST_START_LAUNCH: assert property (
    latch && wr_addr == acsc_pkg::ADDR_ADC_CTRL && wr_cfg.start_convert_field && !busy
    |=> busy && o_dout_oe && o_dout) else $error("start write did not launch conversion");
  // An ignored write may meet a conversion-clock enable, so the step count may advance but never restart.
  AST_START_IGNORED: assert property (
    latch && wr_addr == acsc_pkg::ADDR_ADC_CTRL && busy && !done
    |=> busy && $stable(run) && edge_cnt == (!$past(tick) ? $past(edge_cnt)
      : ($past(edge_cnt) == acsc_pkg::LOAD_EDGE) ? acsc_pkg::SAMPLE_EDGE : $past(edge_cnt) + 4'h1))
    else $error("start write disturbed running conversion");
  AST_MUX_REF: assert property (
    latch && wr_addr == acsc_pkg::ADDR_ADC_CTRL && wr_cfg.start_convert_field && !busy
    |=> o_input_select == $past(wr_cfg.input_select)
      && o_reference_select == $past(wr_cfg.reference_select_field))
    else $error("mux or reference not taken from start word");
  AST_DIV_SPACING: assert property (
    tick && run.clock_divisor == 3'h5 && !done
    |=> (!tick && div_cnt == 7'h00) ##31 tick) else $error("divide by thirty-two enable spacing wrong");
  AST_BUSY_HIGH: assert property (
    busy |-> o_dout_oe && o_dout && o_adc_busy) else $error("output not high while busy");
  AST_DONE_LOW: assert property (
    done |=> !busy && o_dout_oe && !o_dout && !cfg.start_convert_field) else $error("completion not flagged low");
  AST_CS_RELEASE: assert property (
    dstate == acsc_pkg::DOUT_SHIFT && cs_rise |=> !o_dout_oe) else $error("output not released at select rise");
  AST_NO_RESULT: assert property (
    dstate == acsc_pkg::DOUT_READY && cs_fall && !cfg.result_output_enable
    |=> !o_dout_oe) else $error("result presented while disabled");
  AST_SHIFT_MSB: assert property (
    dstate == acsc_pkg::DOUT_READY && cs_fall && cfg.result_output_enable
    |=> o_dout_oe && o_dout == result[9]) else $error("first shifted bit not msb");
  AST_NULL_ADDR: assert property (
    latch && wr_addr == 4'hF |=> $stable(cfg) && $stable(dac) && $stable(pwr))
    else $error("address fifteen changed a register");
  AST_SHUTDOWN: assert property (
    pwr == acsc_pkg::shutdown_state |-> o_dac_off && o_dac == 36'h0) else $error("dac outputs not zero in shutdown");
  AST_KEEP: assert property (
    pwr != acsc_pkg::shutdown_state |-> o_dac == dac) else $error("dac outputs not held outside shutdown");

endmodule

// ===== acsc_host.sv
module acsc_host (
  input  wire logic i_core_clk,
  input  wire logic i_dout,
  input  wire logic i_dout_oe,
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_din
);
  timeunit 1ns;
  timeprecision 1ns;

  int phase = 6;

  initial begin
    o_cs_n = 1'h1;
    o_sclk = 1'h1;
    o_din  = 1'h1;
  end

  // The first result bit is taken before the first serial clock fall, the rest before each of the next nine falls.
  task automatic xfer(input logic [15:0] w, output logic [9:0] rd, output logic oe);
    o_cs_n = 1'h0;
    repeat (phase) @(negedge i_core_clk);
    oe = i_dout_oe;
    for (int k = 15; k >= 0; k--) begin
      if (k > 5) rd[k-6] = (i_dout_oe === 1'h1) ? i_dout : 1'hz;
      o_sclk = 1'h0;
      o_din  = w[k];
      repeat (phase) @(negedge i_core_clk);
      o_sclk = 1'h1;
      repeat (phase) @(negedge i_core_clk);
    end
    o_cs_n = 1'h1;
    // A released data line must not keep its last value, so it flips.
    o_din  = ~o_din;
    repeat (8) @(negedge i_core_clk);
  endtask
endmodule

// ===== testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic                clk;
  logic                nrst;
  logic                cs_n;
  logic                sclk;
  logic                din;
  logic                sar_cmp;
  logic                dout;
  logic                oe;
  logic                busy;
  logic                ref_sel;
  logic                dac_off;
  logic [9:0]          trial;
  logic [1:0]          isel;
  acsc_pkg::acsc_dac_t dac;
  logic [9:0]          tbl [4];
  int                  fail_count = 0;
  int                  cmp_count = 0;
  int                  exp_q [$];
  int                  busy_len = 0;
  int                  samp_len = 0;
  int                  exp_s [$];
  logic                samp;

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Each mux input carries its own level, so a wrong selection shows in the result.
  assign sar_cmp = (tbl[isel] >= trial);

  acsc_aux_converter dut (
    .i_core_clk(clk), .i_nrst(nrst), .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din),
    .i_sar_cmp(sar_cmp), .o_dout(dout), .o_dout_oe(oe), .o_sample(samp), .o_sar_trial(trial),
    .o_input_select(isel), .o_reference_select(ref_sel), .o_adc_busy(busy), .o_dac(dac),
    .o_dac_off(dac_off)
  );

  acsc_host host (
    .i_core_clk(clk), .i_dout(dout), .i_dout_oe(oe), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din)
  );

  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(negedge clk) begin
    if (samp === 1'h1) begin
      samp_len++;
    end
    if (busy === 1'h1) begin
      busy_len++;
    end else if (busy_len != 0) begin
      chk("conversion_time", exp_q.pop_front(), busy_len);
      chk("sample_count", exp_s.pop_front(), samp_len);
      chk("ready_line", 2'h2, {oe, dout});
      busy_len = 0;
      samp_len = 0;
    end
  end

  initial begin
    #1000000;
    fail_count++;
    end_sim();
  end

  initial begin
    logic [15:0] w;
    logic [9:0]  rd;
    logic        oe_seen;
    logic [1:0]  mux;
    logic        rf;
    logic        en;
    logic [35:0] dv;
    logic [2:0]  dc;
    logic [3:0]  bad [3] = '{4'h0, 4'h6, 4'hF};
    nrst = 1'h0;
    void'($urandom(45886));
    foreach (tbl[j]) tbl[j] = 10'($urandom);
    repeat (4) @(negedge clk);
    nrst = 1'h1;
    chk("dac_reset", {12'h700, 24'h0}, dac);
    chk("dac_off_reset", 1'h0, dac_off);
    chk("dout_idle", 1'h0, oe);
    repeat (3) @(negedge clk);
    dv = 36'({$urandom, $urandom});
    host.xfer({acsc_pkg::ADDR_DAC_FREQ, dv[35:24]}, rd, oe_seen);
    host.xfer({acsc_pkg::ADDR_DAC_GAIN, dv[23:12]}, rd, oe_seen);
    host.xfer({acsc_pkg::ADDR_DAC_AGC, dv[11:0]}, rd, oe_seen);
    chk("dac_write", dv, dac);
    for (int m = 1; m < 5; m++) begin
      host.xfer({acsc_pkg::ADDR_POWER, 10'h0, 2'(m)}, rd, oe_seen);
      if (m == 3) begin
        dv[23:12] = 12'($urandom);
        host.xfer({acsc_pkg::ADDR_DAC_GAIN, dv[23:12]}, rd, oe_seen);
      end
      chk("dac_power", (m == 3) ? 36'h0 : dv, dac);
      chk("dac_off", m == 3, dac_off);
    end
    foreach (bad[j]) begin
      host.xfer({bad[j], 12'hFFF}, rd, oe_seen);
      chk("dac_unmapped", dv, dac);
      chk("busy_unmapped", 1'h0, busy);
    end
    // At this system clock only divisors of 32 and up keep the conversion clock within its limit.
    for (int i = 0; i < 8; i++) begin
      mux = 2'($urandom);
      rf = 1'($urandom);
      en = i[0];
      dc = 3'((i < 3) ? 7 - i : 5);
      w = {acsc_pkg::ADDR_ADC_CTRL, 1'h0, en, dc, 3'(i), mux, rf, 1'h1};
      exp_q.push_back(12 * (1 << ((i > 5) ? 5 : i)) * (1 << dc));
      exp_s.push_back(1 << ((i > 5) ? 5 : i));
      host.phase = 5 + i % 4;
      host.xfer(w, rd, oe_seen);
      chk("start_state", {3'h7, mux, rf}, {busy, oe, dout, isel, ref_sel});
      host.xfer(w, rd, oe_seen);
      for (int t = 0; t < 13000 && busy !== 1'h0; t++) @(negedge clk);
      chk("busy_end", 1'h0, busy);
      host.xfer(16'hFFFF, rd, oe_seen);
      chk("read_enable", en, oe_seen);
      if (en) chk("read_data", tbl[mux], rd);
      chk("released", 1'h0, oe);
    end
    end_sim();
  end
endmodule
